// [design/serial_port_zero.sv]
// Asynchronous serial port zero with an APB register slave.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module serial_port_zero (
   // Clock, reset and clock enable.
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CE,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   // Serial lines and timer five transfer clock pulse.
   input wire logic RX_LINE,
   input wire logic TIMER5_TICK,
   output logic TX_LINE
);
   import serial_port_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] ctrl2;
      logic [7:0] txbuf;
      logic [7:0] rxbuf;
      logic parity_mismatch_flag;
      logic framing_flag;
      logic oerr;
      logic rbfl;
      logic tx_done_flag;
      logic tx_buffer_empty_flag;
      logic tx_pend;
      logic arm;
      logic [8:0] div;
      logic filt;
      logic [6:0] fcnt;
      tx_state_t tx_st;
      logic [3:0] tx_rt;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_par;
      logic tx_line;
      logic tx_irq;
      rx_state_t rx_st;
      logic [3:0] rx_rt;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic [1:0] smp;
      logic rx_parity_mismatch_flag;
      logic rx_framing_flag;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } state_t;

   state_t st_q;
   state_t st_d;
   logic acc;
   logic tick;
   logic vote;
   logic rx_done;
   logic fe_now;
   logic [8:0] divisor;
   logic [6:0] flen;
   logic [7:0] flags;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.tx_irq = 1'b0;
      rx_done = 1'b0;
      fe_now = 1'b0;
      acc = PSEL && PENABLE && st_q.pready;
      flags = {st_q.parity_mismatch_flag, st_q.framing_flag, st_q.oerr, st_q.rbfl, st_q.tx_done_flag, st_q.tx_buffer_empty_flag, 2'b00};
      vote = (st_q.smp[0] & st_q.smp[1]) | (st_q.smp[0] & st_q.filt) | (st_q.smp[1] & st_q.filt);

      // APB answer one cycle into the access phase.
      st_d.pready = PSEL && PENABLE && !st_q.pready;
      if (PSEL && PENABLE && !st_q.pready) begin
         st_d.prdata = 32'h0000_0000;
         st_d.pslverr = 1'b0;
         case (PADDR)
            ADDR_CTRL: begin
               if (!PWRITE) begin
                  st_d.prdata = {24'h00_0000, flags};
               end
            end
            ADDR_DATA: begin
               if (!PWRITE) begin
                  st_d.prdata = {24'h00_0000, st_q.rxbuf};
               end
            end
            ADDR_CTRL2: begin
               st_d.prdata = 32'h0000_0000;
            end
            default: begin
               st_d.pslverr = 1'b1;
            end
         endcase
      end

      // Side effects happen at the completing edge only.
      if (acc && !st_q.pslverr) begin
         if (PWRITE && PADDR == ADDR_CTRL) begin
            st_d.ctrl = PWDATA[7:0];
         end
         if (PWRITE && PADDR == ADDR_CTRL2) begin
            st_d.ctrl2 = PWDATA[7:0];
         end
         if (!PWRITE && PADDR == ADDR_CTRL) begin
            st_d.arm = 1'b1;
         end
         if (!PWRITE && PADDR == ADDR_DATA && st_q.arm) begin
            st_d.arm = 1'b0;
            st_d.parity_mismatch_flag = 1'b0;
            st_d.framing_flag = 1'b0;
            st_d.oerr = 1'b0;
            st_d.rbfl = 1'b0;
         end
         if (PWRITE && PADDR == ADDR_DATA) begin
            st_d.txbuf = PWDATA[7:0];
            if (st_q.arm && st_q.ctrl[TXE_BIT]) begin
               st_d.arm = 1'b0;
               st_d.tx_buffer_empty_flag = 1'b0;
               st_d.tx_pend = 1'b1;
            end
         end
      end

      if (!st_q.ctrl[TXE_BIT]) begin
         st_d.tx_pend = 1'b0;
         st_d.tx_buffer_empty_flag = 1'b1;
      end

      case (st_q.ctrl[BRG_LSB +: 3])
         3'h0: divisor = DIV_0;
         3'h1: divisor = DIV_1;
         3'h2: divisor = DIV_2;
         3'h3: divisor = DIV_3;
         3'h4: divisor = DIV_4;
         3'h5: divisor = DIV_5;
         default: divisor = DIV_7;
      endcase
      if (st_q.ctrl[BRG_LSB +: 3] == BRG_TIMER) begin
         tick = TIMER5_TICK;
         st_d.div = 9'h000;
      end else begin
         tick = (st_q.div == 9'(divisor - 9'h001));
         st_d.div = tick ? 9'h000 : 9'(st_q.div + 9'h001);
      end

      case (st_q.ctrl2[FILT_LSB +: 2])
         2'h1: flen = FILT_LEN_1;
         2'h2: flen = FILT_LEN_2;
         2'h3: flen = FILT_LEN_3;
         default: flen = 7'h00;
      endcase
      if (flen == 7'h00) begin
         st_d.filt = RX_LINE;
         st_d.fcnt = 7'h00;
      end else if (RX_LINE == st_q.filt) begin
         st_d.fcnt = 7'h00;
      end else if (st_q.fcnt == 7'(flen - 7'h01)) begin
         st_d.filt = RX_LINE;
         st_d.fcnt = 7'h00;
      end else begin
         st_d.fcnt = 7'(st_q.fcnt + 7'h01);
      end

      // Transmitter; sixteen ticks per bit
      if (tick && st_q.tx_st != TX_IDLE) begin
         st_d.tx_rt = 4'(st_q.tx_rt + 4'h1);
      end
      case (st_q.tx_st)
         TX_IDLE: begin
            st_d.tx_line = 1'b1;
            if (tick && st_q.ctrl[TXE_BIT] && st_q.tx_pend) begin
               st_d.tx_st = TX_START;
               st_d.tx_sh = st_q.txbuf;
               st_d.tx_par = ^st_q.txbuf ^ ~st_q.ctrl[EVEN_BIT];
               st_d.tx_pend = 1'b0;
               st_d.tx_rt = 4'h0;
               st_d.tx_bit = 3'h0;
               st_d.tx_line = 1'b0;
               st_d.tx_done_flag = 1'b0;
               st_d.tx_irq = 1'b1;
               st_d.tx_buffer_empty_flag = 1'b1;
            end
         end
         TX_START: begin
            if (tick && st_q.tx_rt == RT_LAST) begin
               st_d.tx_st = TX_DATA;
               st_d.tx_line = st_q.tx_sh[0];
            end
         end
         TX_DATA: begin
            if (tick && st_q.tx_rt == RT_LAST) begin
               st_d.tx_sh = st_q.tx_sh >> 1;
               if (st_q.tx_bit == 3'h7) begin
                  st_d.tx_st = st_q.ctrl[PAR_ADD_BIT] ? TX_PAR : TX_STOP;
                  st_d.tx_line = st_q.ctrl[PAR_ADD_BIT] ? st_q.tx_par : 1'b1;
                  st_d.tx_bit = 3'h0;
               end else begin
                  st_d.tx_bit = 3'(st_q.tx_bit + 3'h1);
                  st_d.tx_line = st_q.tx_sh[1];
               end
            end
         end
         TX_PAR: begin
            if (tick && st_q.tx_rt == RT_LAST) begin
               st_d.tx_st = TX_STOP;
               st_d.tx_line = 1'b1;
            end
         end
         TX_STOP: begin
            if (tick && st_q.tx_rt == RT_LAST) begin
               if (st_q.ctrl[TX_STOP_BIT] && st_q.tx_bit == 3'h0) begin
                  st_d.tx_bit = 3'h1;
               end else begin
                  st_d.tx_st = TX_IDLE;
                  st_d.tx_done_flag = st_q.tx_buffer_empty_flag;
               end
            end
         end
         default: begin
            st_d.tx_st = TX_IDLE;
            st_d.tx_line = 1'b1;
         end
      endcase

      // Receiver
      if (tick && st_q.rx_st != RX_IDLE) begin
         st_d.rx_rt = 4'(st_q.rx_rt + 4'h1);
         if (st_q.rx_rt == RT_S1) begin
            st_d.smp[0] = st_q.filt;
         end
         if (st_q.rx_rt == RT_S2) begin
            st_d.smp[1] = st_q.filt;
         end
      end
      case (st_q.rx_st)
         RX_IDLE: begin
            if (tick && st_q.ctrl[RXE_BIT] && !st_q.filt && !st_q.oerr) begin
               st_d.rx_st = RX_START;
               st_d.rx_rt = 4'h0;
               st_d.rx_bit = 3'h0;
               st_d.rx_parity_mismatch_flag = 1'b0;
               st_d.rx_framing_flag = 1'b0;
            end
         end
         RX_START: begin
            if (tick && st_q.rx_rt == RT_S3 && vote) begin
               st_d.rx_st = RX_IDLE;
            end else if (tick && st_q.rx_rt == RT_LAST) begin
               st_d.rx_st = RX_DATA;
            end
         end
         RX_DATA: begin
            if (tick && st_q.rx_rt == RT_S3) begin
               st_d.rx_sh = {vote, st_q.rx_sh[7:1]};
            end
            if (tick && st_q.rx_rt == RT_LAST) begin
               if (st_q.rx_bit == 3'h7) begin
                  st_d.rx_st = st_q.ctrl[PAR_ADD_BIT] ? RX_PAR : RX_STOP;
                  st_d.rx_bit = 3'h0;
               end else begin
                  st_d.rx_bit = 3'(st_q.rx_bit + 3'h1);
               end
            end
         end
         RX_PAR: begin
            if (tick && st_q.rx_rt == RT_S3) begin
               st_d.rx_parity_mismatch_flag = vote != (^st_q.rx_sh ^ ~st_q.ctrl[EVEN_BIT]);
            end
            if (tick && st_q.rx_rt == RT_LAST) begin
               st_d.rx_st = RX_STOP;
            end
         end
         RX_STOP: begin
            if (tick && st_q.rx_rt == RT_S3) begin
               fe_now = st_q.rx_framing_flag | ~vote;
               st_d.rx_framing_flag = fe_now;
               if (!(st_q.ctrl2[RX_STOP_BIT] && st_q.rx_bit == 3'h0)) begin
                  rx_done = 1'b1;
                  st_d.rx_st = RX_IDLE;
               end
            end else if (tick && st_q.rx_rt == RT_LAST) begin
               st_d.rx_bit = 3'h1;
            end
         end
         default: begin
            st_d.rx_st = RX_IDLE;
         end
      endcase

      // Frame completion; setting wins over a same-cycle clear.
      if (rx_done) begin
         if (st_q.rbfl) begin
            st_d.oerr = 1'b1;
         end else begin
            st_d.rxbuf = st_q.rx_sh;
            st_d.rbfl = 1'b1;
            st_d.parity_mismatch_flag = st_q.rx_parity_mismatch_flag;
            st_d.framing_flag = fe_now;
         end
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         st_q <= '0;
         st_q.ctrl <= CTRL_RESET;
         st_q.ctrl2 <= CTRL2_RESET;
         st_q.txbuf <= TXBUF_RESET;
         st_q.tx_done_flag <= 1'b1;
         st_q.tx_buffer_empty_flag <= 1'b1;
         st_q.filt <= 1'b1;
         st_q.tx_line <= 1'b1;
         st_q.tx_st <= TX_IDLE;
         st_q.rx_st <= RX_IDLE;
      end else if (CE) begin
         st_q <= st_d;
      end
   end

   assign PREADY = st_q.pready;
   assign PRDATA = st_q.prdata;
   assign PSLVERR = st_q.pslverr;
   assign TX_LINE = st_q.tx_line;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   sequence tx_begin;
      CE && st_q.tx_st == TX_IDLE && st_d.tx_st == TX_START;
   endsequence
   sequence apb_wait;
      CE && PSEL && PENABLE && !st_q.pready;
   endsequence

   a_tx_idle_high: assert property (st_q.tx_st == TX_IDLE |-> st_q.tx_line)
      else $error("transmit line low while idle");
   a_start_bit_low: assert property (tx_begin |=> !st_q.tx_line && st_q.tx_buffer_empty_flag && !st_q.tx_done_flag)
      else $error("frame start without low start bit and empty flag");
   a_send_enabled: assert property (tx_begin |-> st_q.ctrl[TXE_BIT] && st_q.tx_pend)
      else $error("frame started without enable or pending byte");
   a_disable_drops: assert property (CE && !st_q.ctrl[TXE_BIT] |=> !st_q.tx_pend && st_q.tx_buffer_empty_flag)
      else $error("pending byte survived transmit disable");
   a_overrun_keeps: assert property (CE && rx_done && st_q.rbfl |=> st_q.oerr && $stable(st_q.rxbuf))
      else $error("overrun did not flag or buffer changed");
   a_rx_no_abort: assert property (CE && st_q.rx_st == RX_DATA |=> st_q.rx_st != RX_IDLE)
      else $error("receive frame aborted mid data");
   a_apb_answer: assert property (apb_wait |=> st_q.pready ##1 !st_q.pready || !$past(CE))
      else $error("bus answer not a one-cycle ready");
   a_flags_clear: assert property (CE && acc && !PWRITE && PADDR == ADDR_DATA && st_q.arm && !rx_done
         |=> !st_q.rbfl && !st_q.parity_mismatch_flag && !st_q.framing_flag)
      else $error("status then buffer read did not clear flags");
   a_stop_high: assert property (CE && st_q.tx_st == TX_STOP |=> st_q.tx_line)
      else $error("stop bit driven low");

endmodule
`default_nettype wire

// [include/serial_port_pkg.sv]
// Constants, field positions and state encodings of asynchronous serial port zero.
// Function
// - Clearing an enable stops that direction only after the current frame completes.
// - Disabling transmit discards buffered data; re-enable needs a fresh buffer write.
// - A byte buffered while transmit is disabled is never sent.
// - Baud source field picks oscillator divide by 13..416, timer five, or 96.
// - Timer five source gives a bit rate of its pulse rate over sixteen.
// - Transmit stop length bit selects one or two high stop bits.
// - Receive stop length bit sets how many stop bits the receiver expects.
// - Parity add bit inserts parity; polarity bit picks odd (0) or even (1).
// - Frame is low start, data bit 0 to 7, optional parity, stops.
// - Baud and parity settings are shared by transmit and receive.
// - Noise filter field rejects pulses under 31, 63 or 127 oscillator periods.
// - Pulses over 96, 192 or 384 periods always pass the filter.
// - While receive is enabled and overrun is clear, the idle receiver samples the line each baud tick until it sees low.
// - Each received bit is the majority of samples at ticks 7, 8, 9.
// - Status bits 7 to 2 hold the six flags; reset value is 0x0C.
// - The buffer empty flag sets whenever the transmit event fires.
// - Parity mismatch sets the parity flag; status then buffer read clears it.
// - A stop bit sampled low sets the framing flag.
// - A frame arriving into a full buffer sets overrun and is dropped.
package serial_port_pkg;

   // -----------------------------------------------------------------
   // Register indices and byte addresses
   // -----------------------------------------------------------------
   localparam logic [15:0] CTRL_IDX = 16'h0025;
   localparam logic [15:0] DATA_IDX = 16'h0F9B;
   localparam logic [15:0] CTRL2_IDX = 16'h0026;
   localparam logic [15:0] ADDR_CTRL = {CTRL_IDX[13:0], 2'b00};
   localparam logic [15:0] ADDR_DATA = {DATA_IDX[13:0], 2'b00};
   localparam logic [15:0] ADDR_CTRL2 = {CTRL2_IDX[13:0], 2'b00};

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int TXE_BIT = 7;
   localparam int RXE_BIT = 6;
   localparam int TX_STOP_BIT = 5;
   localparam int EVEN_BIT = 4;
   localparam int PAR_ADD_BIT = 3;
   localparam int BRG_LSB = 0;
   localparam int RX_STOP_BIT = 0;
   localparam int FILT_LSB = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [7:0] TXBUF_RESET = 8'h00;

   // -----------------------------------------------------------------
   // Baud divisors, filter lengths and bit timing
   // -----------------------------------------------------------------
   localparam logic [2:0] BRG_TIMER = 3'h6;
   localparam logic [8:0] DIV_0 = 9'h00D;
   localparam logic [8:0] DIV_1 = 9'h01A;
   localparam logic [8:0] DIV_2 = 9'h034;
   localparam logic [8:0] DIV_3 = 9'h068;
   localparam logic [8:0] DIV_4 = 9'h0D0;
   localparam logic [8:0] DIV_5 = 9'h1A0;
   localparam logic [8:0] DIV_7 = 9'h060;
   localparam logic [6:0] FILT_LEN_1 = 7'h1F;
   localparam logic [6:0] FILT_LEN_2 = 7'h3F;
   localparam logic [6:0] FILT_LEN_3 = 7'h7F;
   localparam logic [3:0] RT_LAST = 4'hF;
   localparam logic [3:0] RT_S1 = 4'h7;
   localparam logic [3:0] RT_S2 = 4'h8;
   localparam logic [3:0] RT_S3 = 4'h9;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
   } tx_state_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
   } rx_state_t;

endpackage

// [test/remote_serial_model.sv]
// Remote serial device model on the transmit and receive lines.
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model #(parameter int BIT_CLKS = 208) (
   // Clock and serial lines.
   input wire logic clk,
   input wire logic tx_line,
   output logic rx_line,
   // Frame format in use.
   input wire logic par_en,
   input wire logic par_even,
   input wire logic two_stop
);
   logic [7:0] got_byte = 8'h00;
   logic got_par = 1'b0;
   logic stops_ok = 1'b0;
   int fcount = 0;
   int cyc = 0;
   int gap = 0;
   int last_start = 0;

   initial rx_line = 1'b1;
   always @(posedge clk) cyc <= cyc + 1;

   // ------------------------------------------------------------
   // Frame decode and frame send
   // ------------------------------------------------------------
   // mid-bit decode
   initial begin
      forever begin
         @(negedge tx_line);
         gap = cyc - last_start;
         last_start = cyc;
         repeat (BIT_CLKS / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            got_byte[i] = tx_line;
         end
         if (par_en) begin
            repeat (BIT_CLKS) @(posedge clk);
            got_par = tx_line;
         end
         repeat (BIT_CLKS) @(posedge clk);
         stops_ok = tx_line;
         if (two_stop) begin
            repeat (BIT_CLKS) @(posedge clk);
            stops_ok = stops_ok & tx_line;
         end
         fcount++;
      end
   end

   task automatic send_frame(input logic [7:0] b, input logic bad_par, input logic bad_stop);
      logic [11:0] bits;
      int n;
      n = 10 + int'(par_en) + int'(two_stop);
      bits = par_en ? {2'b11, ~^b ^ par_even ^ bad_par, b, 1'b0} : {3'b111, b, 1'b0};
      bits[n - 1] = ~bad_stop;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_line <= bits[i];
         repeat (BIT_CLKS - 1) @(posedge clk);
      end
      @(posedge clk);
      rx_line <= 1'b1;
   endtask

   task automatic glitch(input int len);
      @(posedge clk);
      rx_line <= 1'b0;
      repeat (len) @(posedge clk);
      rx_line <= 1'b1;
   endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for serial port zero over APB.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import serial_port_pkg::*;
   logic CLK_SYS = 1'b0;
   logic RESETN = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [15:0] PADDR = 16'h0000;
   logic [31:0] PWDATA = 32'h0;
   logic TIMER5_TICK = 1'b0;
   logic CE = 1'b1;
   logic PREADY, PSLVERR, TX_LINE, RX_LINE;
   logic [31:0] PRDATA, rd;
   logic [1:0] tmr_cnt = 2'h0;
   logic err, par_en = 1'b0, par_even = 1'b0, two_stop = 1'b0;
   logic [7:0] b1, b2;
   logic [7:0] modes [4] = '{8'h80, 8'hA0, 8'h88, 8'hB8};
   logic [7:0] rx_c1 [4] = '{8'h40, 8'h48, 8'h58, 8'h40};
   logic [7:0] rx_c2 [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
   logic [7:0] rx_b [4] = '{8'h5A, 8'h69, 8'h33, 8'hE1};
   logic [1:0] rx_bad [4] = '{2'h0, 2'h2, 2'h0, 2'h1};
   logic [7:0] rx_st [4] = '{8'h1C, 8'h9C, 8'h1C, 8'h5C};
   int divs [8] = '{13, 26, 52, 104, 208, 416, 4, 96};
   int glen [4] = '{0, 25, 57, 120};
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int base, k, n, lo;

   always #50 CLK_SYS = ~CLK_SYS;

   serial_port_zero i_serial_port_zero (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CE(CE), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
      .PRDATA(PRDATA), .PSLVERR(PSLVERR), .RX_LINE(RX_LINE), .TIMER5_TICK(TIMER5_TICK), .TX_LINE(TX_LINE));
   remote_serial_model i_remote_serial_model (.clk(CLK_SYS), .tx_line(TX_LINE), .rx_line(RX_LINE),
      .par_en(par_en), .par_even(par_even), .two_stop(two_stop));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK_SYS);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK_SYS);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string what);
      apb(1'b0, a, 32'h0);
      check_val(what, {24'h0, e}, rd);
   endtask

   task automatic tx_byte(input logic [7:0] b);
      apb(1'b0, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_DATA, {24'h0, b});
   endtask

   task automatic wait_frames(input int target);
      int w;
      w = 0;
      while (i_remote_serial_model.fcount < target && w < 6000) begin
         @(posedge CLK_SYS);
         w++;
      end
      check_val("frame count", target, i_remote_serial_model.fcount);
   endtask

   task automatic rx_send(input logic [7:0] b, input logic [1:0] bad);
      i_remote_serial_model.send_frame(b, bad[1], bad[0]);
      repeat (220) @(posedge CLK_SYS);
   endtask

   always @(posedge CLK_SYS) begin
      tmr_cnt <= tmr_cnt + 2'h1;
      TIMER5_TICK <= &tmr_cnt;
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         num_errors++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      @(posedge CLK_SYS);
      rd_chk(ADDR_CTRL, 8'h0C, "status reset");
      rd_chk(ADDR_CTRL2, 8'h00, "control two read");
      apb(1'b0, 16'h0010, 32'h0);
      check_val("unmapped error", 32'h1, {31'h0, err});
      check_val("tx idle", 32'h1, {31'h0, TX_LINE});
      $display("Test reset done");
      foreach (modes[m]) begin
         {two_stop, par_even, par_en} = modes[m][5:3];
         apb(1'b1, ADDR_CTRL, {24'h0, modes[m]});
         base = i_remote_serial_model.fcount;
         b1 = 8'hA5 ^ 8'(m);
         b2 = 8'h3C + 8'(m);
         tx_byte(b1);
         k = 0;
         do begin
            apb(1'b0, ADDR_CTRL, 32'h0);
            k++;
         end while (rd[2] !== 1'b1 && k < 50);
         apb(1'b1, ADDR_DATA, {24'h0, b2});
         wait_frames(base + 1);
         check_val("tx byte one", {24'h0, b1}, {24'h0, i_remote_serial_model.got_byte});
         if (par_en) check_val("tx parity", {31'h0, ~^b1 ^ par_even}, {31'h0, i_remote_serial_model.got_par});
         wait_frames(base + 2);
         check_val("tx byte two", {24'h0, b2}, {24'h0, i_remote_serial_model.got_byte});
         check_val("tx stops", 32'h1, {31'h0, i_remote_serial_model.stops_ok});
         lo = 208 * (10 + int'(par_en) + int'(two_stop));
         n = i_remote_serial_model.gap;
         check_val("frame spacing", 32'h1, {31'h0, n >= lo && n <= lo + 30});
         repeat (600) @(posedge CLK_SYS);
         rd_chk(ADDR_CTRL, 8'h0C, "tx end flags");
         check_val("tx idle after", 32'h1, {31'h0, TX_LINE});
      end
      $display("Test tx formats done");
      {two_stop, par_even, par_en} = 3'h0;
      apb(1'b1, ADDR_CTRL, 32'h0);
      base = i_remote_serial_model.fcount;
      tx_byte(8'h55);
      repeat (2600) @(posedge CLK_SYS);
      apb(1'b1, ADDR_CTRL, 32'h80);
      repeat (2600) @(posedge CLK_SYS);
      check_val("no stale send", base, i_remote_serial_model.fcount);
      rd_chk(ADDR_CTRL, 8'h0C, "buffer still empty");
      tx_byte(8'hC3);
      k = 0;
      while (TX_LINE !== 1'b0 && k < 500) begin
         @(posedge CLK_SYS);
         k++;
      end
      repeat (600) @(posedge CLK_SYS);
      apb(1'b1, ADDR_CTRL, 32'h0);
      wait_frames(base + 1);
      check_val("frame finished", 32'hC3, {24'h0, i_remote_serial_model.got_byte});
      check_val("finished stops", 32'h1, {31'h0, i_remote_serial_model.stops_ok});
      $display("Test tx disable done");
      foreach (rx_b[i]) begin
         apb(1'b1, ADDR_CTRL2, {24'h0, rx_c2[i]});
         apb(1'b1, ADDR_CTRL, {24'h0, rx_c1[i]});
         {two_stop, par_even, par_en} = {rx_c2[i][0], rx_c1[i][4:3]};
         rx_send(rx_b[i], rx_bad[i]);
         rd_chk(ADDR_CTRL, rx_st[i], "rx status");
         rd_chk(ADDR_DATA, rx_b[i], "rx byte");
         rd_chk(ADDR_CTRL, 8'h0C, "rx flags cleared");
      end
      {two_stop, par_even, par_en} = 3'h0;
      apb(1'b1, ADDR_CTRL2, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h40);
      rx_send(8'h11, 2'h0);
      rx_send(8'h22, 2'h0);
      rd_chk(ADDR_CTRL, 8'h3C, "overrun status");
      rd_chk(ADDR_DATA, 8'h11, "kept byte");
      rd_chk(ADDR_CTRL, 8'h0C, "overrun cleared");
      for (int f = 1; f < 4; f++) begin
         apb(1'b1, ADDR_CTRL2, {24'h0, 5'h0, 2'(f), 1'b0});
         i_remote_serial_model.glitch(glen[f]);
         repeat (2400) @(posedge CLK_SYS);
         rd_chk(ADDR_CTRL, 8'h0C, "glitch rejected");
         rx_send(8'h96 ^ 8'(f), 2'h0);
         rd_chk(ADDR_CTRL, 8'h1C, "long pulses pass");
         rd_chk(ADDR_DATA, 8'h96 ^ 8'(f), "filtered byte");
      end
      $display("Test receive done");
      apb(1'b1, ADDR_CTRL, 32'h0);
      foreach (divs[c]) begin
         apb(1'b1, ADDR_CTRL, {24'h0, 8'h80 | 8'(c)});
         tx_byte(8'h01);
         k = 0;
         n = 0;
         while (TX_LINE !== 1'b0 && k < 8000) begin
            @(posedge CLK_SYS);
            k++;
         end
         // Frozen cycles must stretch the start bit, so they are not counted.
         CE <= 1'b0;
         repeat (20) @(posedge CLK_SYS);
         CE <= 1'b1;
         while (TX_LINE === 1'b0 && n < 8000) begin
            @(posedge CLK_SYS);
            n++;
         end
         check_val("start bit length", 16 * divs[c], n);
         RESETN <= 1'b0;
         @(posedge CLK_SYS);
         RESETN <= 1'b1;
         @(posedge CLK_SYS);
      end
      $display("Test baud sources done");
      stop_test();
   end
endmodule
`default_nettype wire
